// [hw/dac_clock_monitor_dc_test.sv]
// Sample clock supervisor and dc test controls, with its serial configuration port.
// Assumes the serial clock runs well below a quarter of mclk and the detector levels are asynchronous.
// Functional notes
// - With the detector enabled and the single-ended option set, a non-differential clock forces the DAC cores down.
// - With the detector enabled and the clock-loss option set, a lost clock forces both DAC cores down.
// - Read-only bit 2 shows the sample clock running; resets to zero.
// - Read-only bit 1 shows the sample clock is differential.
// - Bit 0 enables the clock detector; resets to zero.
// - Digital test bit 1 enables constant output test mode; resets to zero.
// - Digital test bit 0 shuts down the core digital clock; resets to zero.
// - In-phase constant low byte is a read-write register resetting to zero.
// - In-phase constant high byte is a separate read-write register.
// - Quadrature constant has low and high read-write bytes resetting to zero.
`timescale 1ns/1ps
`include "dac_clock_monitor_defines.svh"

module dac_clock_monitor_dc_test (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Serial configuration port
	input wire logic spi_sclk,
	input wire logic spi_csb,
	input wire logic spi_sdio_in,
	output logic spi_sdio_out,
	output logic spi_sdio_oe_n,
	// Clock detector levels
	input wire logic clock_present_in,
	input wire logic clock_balanced_in,
	// Converter controls
	output logic dac_cores_power_down,
	output logic core_clock_shutdown,
	output logic constant_output_test_enable,
	output logic [15:0] constant_value_inphase,
	output logic [15:0] constant_value_quadrature
);
	import dac_clock_monitor_pkg::*;

	// ============================================================
	// Pin synchronisation.
	dac_clock_monitor_pkg::pin_levels_s pins_s;
	logic sclk_q_r;
	logic sclk_rise;
	logic sclk_fall;

	pin_sync #(
		.WIDTH(5)
	) u_pin_sync (
		.mclk(mclk),
		.reset_n(reset_n),
		.async_in({spi_sclk, spi_csb, spi_sdio_in, clock_present_in, clock_balanced_in}),
		.sync_out(pins_s)
	);

	// Edges are taken from the synchronised clock only.
	assign sclk_rise = pins_s.sclk & ~sclk_q_r;
	assign sclk_fall = ~pins_s.sclk & sclk_q_r;

	// ============================================================
	// Register storage.
	logic [2:0] monitor_rsvd_r;
	logic dac_off_on_single_ended_r;
	logic dac_off_on_clock_loss_r;
	logic detector_enable_r;
	logic clock_present_r;
	logic sample_clock_balanced_r;
	logic [5:0] test_rsvd_r;

	// ============================================================
	// Read decode, shared by every read frame.
	function automatic logic [7:0] read_mux(input logic [14:0] addr);
		logic [7:0] val;
		val = 8'h00;
		if (addr == `OFS_CLOCK_MONITOR_CTRL) begin
			val = {monitor_rsvd_r, dac_off_on_single_ended_r, dac_off_on_clock_loss_r,
				clock_present_r, sample_clock_balanced_r, detector_enable_r};
		end else if (addr == `OFS_DIGITAL_TEST_CTRL) begin
			val = {test_rsvd_r, constant_output_test_enable, core_clock_shutdown};
		end else if (addr == `OFS_CONST_INPHASE_LOW) begin
			val = constant_value_inphase[7:0];
		end else if (addr == `OFS_CONST_INPHASE_HIGH) begin
			val = constant_value_inphase[15:8];
		end else if (addr == `OFS_CONST_QUAD_LOW) begin
			val = constant_value_quadrature[7:0];
		end else if (addr == `OFS_CONST_QUAD_HIGH) begin
			val = constant_value_quadrature[15:8];
		end
		return val;
	endfunction

	// ============================================================
	// Serial frame engine.
	dac_clock_monitor_pkg::port_state_e state_r;
	logic [23:0] shift_r;
	logic [23:0] shift_nxt;
	logic [4:0] bit_cnt_r;
	logic [4:0] bit_cnt_nxt;
	logic is_read_r;
	logic [14:0] addr_r;
	logic [7:0] rd_shift_r;
	dac_clock_monitor_pkg::reg_write_s wr_r;
	logic instr_done;
	logic frame_done;

	// Bit counting happens on the rising serial edge; data is driven on the falling one.
	assign shift_nxt = {shift_r[22:0], pins_s.sdio};
	assign bit_cnt_nxt = bit_cnt_r + 5'h01;
	assign instr_done = sclk_rise && (bit_cnt_nxt == `FRAME_INSTR_BITS);
	assign frame_done = sclk_rise && (bit_cnt_nxt == `FRAME_TOTAL_BITS);

	// Frame state and shifting; chip select high aborts any frame in progress.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
			shift_r <= 24'h000000;
			bit_cnt_r <= 5'h00;
			is_read_r <= 1'b0;
			addr_r <= 15'h0000;
		end else if (pins_s.csb) begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 5'h00;
		end else begin
			if (sclk_rise && (state_r != ST_DONE)) begin
				shift_r <= shift_nxt;
				bit_cnt_r <= bit_cnt_nxt;
			end
			case (state_r)
				ST_IDLE: begin
					state_r <= ST_INSTR;
				end
				ST_INSTR: begin
					if (instr_done) begin
						is_read_r <= shift_nxt[15];
						addr_r <= shift_nxt[14:0];
						state_r <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (frame_done) begin
						state_r <= ST_DONE;
					end
				end
				default: begin
					state_r <= ST_DONE;
				end
			endcase
		end
	end

	// Read data loads at the end of the instruction and shifts out MSB first.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rd_shift_r <= 8'h00;
			spi_sdio_out <= 1'b0;
			spi_sdio_oe_n <= 1'b1;
		end else if (pins_s.csb || (state_r == ST_DONE)) begin
			spi_sdio_oe_n <= 1'b1;
		end else if ((state_r == ST_INSTR) && instr_done) begin
			rd_shift_r <= read_mux(shift_nxt[14:0]);
		end else if ((state_r == ST_DATA) && is_read_r && sclk_fall) begin
			spi_sdio_out <= rd_shift_r[7];
			spi_sdio_oe_n <= 1'b0;
			rd_shift_r <= {rd_shift_r[6:0], 1'b0};
		end
	end

	// A write completes only with the full data byte; a short frame writes nothing.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			wr_r <= '0;
			sclk_q_r <= 1'b0;
		end else begin
			sclk_q_r <= pins_s.sclk;
			wr_r.valid <= !pins_s.csb && (state_r == ST_DATA) && !is_read_r && frame_done;
			wr_r.addr <= addr_r;
			wr_r.data <= shift_nxt[7:0];
		end
	end

	// ============================================================
	// Register write decode.
	logic hit_monitor;
	logic hit_test;
	logic hit_i_low;
	logic hit_i_high;
	logic hit_q_low;
	logic hit_q_high;

	assign hit_monitor = wr_r.valid && (wr_r.addr == `OFS_CLOCK_MONITOR_CTRL);
	assign hit_test = wr_r.valid && (wr_r.addr == `OFS_DIGITAL_TEST_CTRL);
	assign hit_i_low = wr_r.valid && (wr_r.addr == `OFS_CONST_INPHASE_LOW);
	assign hit_i_high = wr_r.valid && (wr_r.addr == `OFS_CONST_INPHASE_HIGH);
	assign hit_q_low = wr_r.valid && (wr_r.addr == `OFS_CONST_QUAD_LOW);
	assign hit_q_high = wr_r.valid && (wr_r.addr == `OFS_CONST_QUAD_HIGH);

	// Clock monitor control; status bits are not writable.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			monitor_rsvd_r <= `RST_MONITOR_RSVD;
			dac_off_on_single_ended_r <= 1'b0;
			dac_off_on_clock_loss_r <= 1'b0;
			detector_enable_r <= 1'b0;
		end else if (hit_monitor) begin
			monitor_rsvd_r <= wr_r.data[7:5];
			dac_off_on_single_ended_r <= wr_r.data[`BIT_DAC_OFF_ON_SINGLE_ENDED];
			dac_off_on_clock_loss_r <= wr_r.data[`BIT_DAC_OFF_ON_CLOCK_LOSS];
			detector_enable_r <= wr_r.data[`BIT_DETECTOR_ENABLE];
		end
	end

	// Digital test controls drive the core clock gate and the test mux directly.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			test_rsvd_r <= `RST_TEST_RSVD;
			constant_output_test_enable <= 1'b0;
			core_clock_shutdown <= 1'b0;
		end else if (hit_test) begin
			test_rsvd_r <= wr_r.data[7:2];
			constant_output_test_enable <= wr_r.data[`BIT_CONSTANT_OUTPUT_TEST_ENABLE];
			core_clock_shutdown <= wr_r.data[`BIT_CORE_CLOCK_SHUTDOWN];
		end
	end

	// Constant test values, one byte per register.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			constant_value_inphase <= {`RST_BYTE, `RST_BYTE};
			constant_value_quadrature <= {`RST_BYTE, `RST_BYTE};
		end else begin
			if (hit_i_low) begin
				constant_value_inphase[7:0] <= wr_r.data;
			end
			if (hit_i_high) begin
				constant_value_inphase[15:8] <= wr_r.data;
			end
			if (hit_q_low) begin
				constant_value_quadrature[7:0] <= wr_r.data;
			end
			if (hit_q_high) begin
				constant_value_quadrature[15:8] <= wr_r.data;
			end
		end
	end

	// ============================================================
	// Clock supervision.
	logic force_off;

	// A disabled detector reports nothing and never forces a power-down.
	assign force_off = detector_enable_r &&
		((dac_off_on_clock_loss_r && !pins_s.present) ||
		(dac_off_on_single_ended_r && !pins_s.balanced));

	// Status follows the detector with the sync delay plus one cycle.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			clock_present_r <= 1'b0;
			sample_clock_balanced_r <= 1'b0;
			dac_cores_power_down <= 1'b0;
		end else begin
			clock_present_r <= detector_enable_r && pins_s.present;
			sample_clock_balanced_r <= detector_enable_r && pins_s.balanced;
			dac_cores_power_down <= force_off;
		end
	end

endmodule

// [hw/dac_clock_monitor_defines.svh]
// Register offsets, field positions, reset values and frame sizes for the clock monitor block.
// Assumes it is included by its bare name from the package and the design modules.
`ifndef DAC_CLOCK_MONITOR_DEFINES_SVH
`define DAC_CLOCK_MONITOR_DEFINES_SVH

// ============================================================
// Register offsets on the serial configuration port.
`define OFS_CLOCK_MONITOR_CTRL 15'h008E
`define OFS_DIGITAL_TEST_CTRL 15'h00F7
`define OFS_CONST_INPHASE_LOW 15'h00F8
`define OFS_CONST_INPHASE_HIGH 15'h00F9
`define OFS_CONST_QUAD_LOW 15'h00FA
`define OFS_CONST_QUAD_HIGH 15'h00FB

// ============================================================
// Field positions in the clock monitor control register.
`define BIT_DAC_OFF_ON_SINGLE_ENDED 4
`define BIT_DAC_OFF_ON_CLOCK_LOSS 3
`define BIT_CLOCK_PRESENT 2
`define BIT_SAMPLE_CLOCK_BALANCED 1
`define BIT_DETECTOR_ENABLE 0

// Field positions in the digital test register.
`define BIT_CONSTANT_OUTPUT_TEST_ENABLE 1
`define BIT_CORE_CLOCK_SHUTDOWN 0

// ============================================================
// Reset values.
`define RST_MONITOR_RSVD 3'h0
`define RST_TEST_RSVD 6'h07
`define RST_BYTE 8'h00

// ============================================================
// Serial frame: read flag, 15 address bits, then one data byte.
`define FRAME_INSTR_BITS 5'h10
`define FRAME_TOTAL_BITS 5'h18

`endif

// [hw/dac_clock_monitor_pkg.sv]
// Types shared by the clock monitor and dc test block.
// Assumes the defines header sits in the include path.
`include "dac_clock_monitor_defines.svh"

package dac_clock_monitor_pkg;

	// ============================================================
	// Serial port frame states, Gray coded along the frame.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_INSTR = 2'h1,
		ST_DATA = 2'h3,
		ST_DONE = 2'h2
	} port_state_e;

	// One register write taken from the serial port.
	typedef struct packed {
		logic valid;
		logic [14:0] addr;
		logic [7:0] data;
	} reg_write_s;

	// Synchronised pin levels.
	typedef struct packed {
		logic sclk;
		logic csb;
		logic sdio;
		logic present;
		logic balanced;
	} pin_levels_s;

endpackage

// [hw/pin_sync.sv]
// Two flip-flop synchroniser for a group of asynchronous pin levels.
// Assumes the levels change slowly compared with mclk.
`timescale 1ns/1ps

module pin_sync #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	// ============================================================
	// The first stage is read only by the second stage.
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// [bench/dac_clock_monitor_dc_test_chk.sv]
// Port checker for the clock monitor and dc test block.
// Assumes serial clock phases of at least four mclk periods and a bound to the top module.
`timescale 1ns/1ps

module dac_clock_monitor_dc_test_chk (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// Serial port
	input wire logic spi_sclk,
	input wire logic spi_csb,
	input wire logic spi_sdio_in,
	input wire logic spi_sdio_out,
	input wire logic spi_sdio_oe_n,
	// Detector levels and converter controls
	input wire logic clock_present_in,
	input wire logic clock_balanced_in,
	input wire logic dac_cores_power_down,
	input wire logic core_clock_shutdown,
	input wire logic constant_output_test_enable,
	input wire logic [15:0] constant_value_inphase,
	input wire logic [15:0] constant_value_quadrature
);
	// ============================================================
	// Helper state
	logic [5:0] sclk_r;
	logic [5:0] bad_r;
	logic [4:0] rise_r;
	logic [3:0] idle_r;
	logic wr_r;
	wire rise_w = sclk_r[1:0] == 2'b01;

	// Histories are free running; the counters clear in reset so that they never hold unknowns.
	always_ff @(posedge mclk) begin
		sclk_r <= {sclk_r[4:0], spi_sclk};
		bad_r <= {bad_r[4:0], !clock_present_in | !clock_balanced_in};
		if (!reset_n || !spi_csb) begin
			idle_r <= 4'h0;
		end else if (idle_r != 4'hF) begin
			idle_r <= idle_r + 4'h1;
		end
		rise_r <= (!reset_n || spi_csb) ? 5'h00 : rise_r + {4'h0, rise_w};
		wr_r <= (!reset_n || spi_csb) ? 1'b0 : ((rise_w && rise_r == 5'h00) ? !spi_sdio_in : wr_r);
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	a_reset_outputs_clear: assert property (disable iff (1'b0) !reset_n |=> spi_sdio_oe_n && !dac_cores_power_down
		&& !core_clock_shutdown && !constant_output_test_enable
		&& constant_value_inphase == 16'h0000 && constant_value_quadrature == 16'h0000)
		else $error("outputs not cleared by reset");
	a_pd_has_cause: assert property (dac_cores_power_down |-> |bad_r[5:1])
		else $error("power down without a clock fault");
	a_pd_clear_good: assert property (bad_r == 6'h00 |-> !dac_cores_power_down)
		else $error("power down with a good clock");
	a_idle_outputs_hold: assert property (idle_r > 4'h8 |-> $stable(constant_value_inphase)
		&& $stable(constant_value_quadrature) && $stable(constant_output_test_enable) && $stable(core_clock_shutdown))
		else $error("control output moved between frames");
	a_oe_idle_off: assert property (idle_r > 4'h5 |-> spi_sdio_oe_n)
		else $error("data pin driven while deselected");
	a_oe_instr_off: assert property (!spi_csb && rise_r < 5'h10 |-> spi_sdio_oe_n)
		else $error("data pin driven during instruction");
	a_oe_write_off: assert property (!spi_csb && wr_r |-> spi_sdio_oe_n)
		else $error("data pin driven in a write frame");
	a_oe_run_eight: assert property ($fell(spi_sdio_oe_n) |=> !spi_sdio_oe_n [*8])
		else $error("read data drive cut short");
	a_bit_stands: assert property (!spi_sdio_oe_n && $past(!spi_sdio_oe_n) && $changed(spi_sdio_out)
		|-> sclk_r[5:1] != 5'h1F && sclk_r[5:1] != 5'h00)
		else $error("read bit changed without a clock edge");

	// Main scenarios.
	c_read: cover property ($fell(spi_sdio_oe_n));
	c_pd: cover property ($rose(dac_cores_power_down));
	c_quad: cover property ($changed(constant_value_quadrature));
endmodule

bind dac_clock_monitor_dc_test dac_clock_monitor_dc_test_chk u_chk (.mclk(mclk), .reset_n(reset_n),
	.spi_sclk(spi_sclk), .spi_csb(spi_csb), .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out),
	.spi_sdio_oe_n(spi_sdio_oe_n), .clock_present_in(clock_present_in), .clock_balanced_in(clock_balanced_in),
	.dac_cores_power_down(dac_cores_power_down), .core_clock_shutdown(core_clock_shutdown),
	.constant_output_test_enable(constant_output_test_enable), .constant_value_inphase(constant_value_inphase),
	.constant_value_quadrature(constant_value_quadrature));

// [bench/tb.sv]
// Self-checking bench for the clock monitor block, driving its serial port pin by pin.
// Assumes a 10 MHz mclk; serial clock phases are six mclk periods so read bits settle first.
`timescale 1ns/1ps

module tb;
	import dac_clock_monitor_pkg::*;

	// ============================================================
	// Signals
	typedef struct packed {
		logic rw;
		logic [8:0] addr;
		logic [7:0] d;
		logic pres;
		logic bal;
		logic pd;
	} row_s;
	logic mclk, reset_n, spi_sclk, spi_csb, host_bit, pres, bal, oe_n, sdo, pd, shut, test_en;
	logic [15:0] cvi, cvq;
	logic [7:0] q;
	int mismatches, n_tests;
	row_s rows [30];

	// The shared data wire carries the device's bit whenever it drives, the host's otherwise.
	wire sdio_wire = oe_n ? host_bit : sdo;

	dac_clock_monitor_dc_test u_dac_clock_monitor_dc_test (.mclk(mclk), .reset_n(reset_n),
		.spi_sclk(spi_sclk), .spi_csb(spi_csb), .spi_sdio_in(sdio_wire), .spi_sdio_out(sdo),
		.spi_sdio_oe_n(oe_n), .clock_present_in(pres), .clock_balanced_in(bal), .dac_cores_power_down(pd),
		.core_clock_shutdown(shut), .constant_output_test_enable(test_en), .constant_value_inphase(cvi),
		.constant_value_quadrature(cvq));

	always #50 mclk = ~mclk;

	// ============================================================
	// Tasks
	task check(input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			mismatches++;
			$display("FAIL %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task end_sim;
		if (mismatches == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// A frame shorter than 24 bits is sent by giving a smaller n; read bits are taken at each rise.
	// During a read the host puts the inverse of the expected byte on the wire, so an undriven pin fails.
	task frame(input logic rw, input logic [8:0] a, input logic [7:0] d, input int n, output logic [7:0] r);
		logic [23:0] w;
		w = {rw, 6'h00, a, rw ? ~d : d};
		r = 8'h00;
		spi_csb = 1'b0;
		for (int i = 23; i > 23 - n; i--) begin
			host_bit = w[i];
			cyc(6);
			spi_sclk = 1'b1;
			if (i < 8) r[i] = sdio_wire;
			cyc(6);
			spi_sclk = 1'b0;
		end
		cyc(6);
		spi_csb = 1'b1;
		cyc(8);
	endtask

	// A hang is cut short here and counted.
	initial begin
		repeat (60000) @(posedge mclk);
		mismatches++;
		end_sim;
	end

	// ============================================================
	// Main sequence
	initial begin
		mclk = 1'b0;
		reset_n = 1'b0;
		spi_sclk = 1'b0;
		spi_csb = 1'b1;
		host_bit = 1'b0;
		pres = 1'b1;
		bal = 1'b1;
		// With only the clock-loss option set, a single-ended clock is reported but powers nothing down.
		rows = '{'{1'b1, 9'h08E, 8'h00, 1'b1, 1'b1, 1'b0}, '{1'b1, 9'h0F7, 8'h1C, 1'b1, 1'b1, 1'b0},
			'{1'b1, 9'h0F8, 8'h00, 1'b1, 1'b1, 1'b0}, '{1'b1, 9'h0F9, 8'h00, 1'b1, 1'b1, 1'b0},
			'{1'b1, 9'h0FA, 8'h00, 1'b1, 1'b1, 1'b0}, '{1'b1, 9'h0FB, 8'h00, 1'b1, 1'b1, 1'b0},
			'{1'b0, 9'h0F8, 8'h5A, 1'b1, 1'b1, 1'b0}, '{1'b0, 9'h0F9, 8'hC3, 1'b1, 1'b1, 1'b0},
			'{1'b0, 9'h0FA, 8'h3C, 1'b1, 1'b1, 1'b0}, '{1'b0, 9'h0FB, 8'hA5, 1'b1, 1'b1, 1'b0},
			'{1'b1, 9'h0F8, 8'h5A, 1'b1, 1'b1, 1'b0}, '{1'b1, 9'h0F9, 8'hC3, 1'b1, 1'b1, 1'b0},
			'{1'b1, 9'h0FA, 8'h3C, 1'b1, 1'b1, 1'b0}, '{1'b1, 9'h0FB, 8'hA5, 1'b1, 1'b1, 1'b0},
			'{1'b0, 9'h0F7, 8'h03, 1'b1, 1'b1, 1'b0}, '{1'b1, 9'h0F7, 8'h03, 1'b1, 1'b1, 1'b0},
			'{1'b0, 9'h100, 8'hFF, 1'b1, 1'b1, 1'b0}, '{1'b1, 9'h100, 8'h00, 1'b1, 1'b1, 1'b0},
			'{1'b0, 9'h08E, 8'h06, 1'b1, 1'b1, 1'b0}, '{1'b1, 9'h08E, 8'h00, 1'b1, 1'b1, 1'b0},
			'{1'b0, 9'h08E, 8'h19, 1'b1, 1'b1, 1'b0}, '{1'b1, 9'h08E, 8'h1F, 1'b1, 1'b1, 1'b0},
			'{1'b1, 9'h08E, 8'h1D, 1'b1, 1'b0, 1'b1}, '{1'b1, 9'h08E, 8'h1B, 1'b0, 1'b1, 1'b1},
			'{1'b0, 9'h08E, 8'h01, 1'b0, 1'b1, 1'b0}, '{1'b1, 9'h08E, 8'h03, 1'b0, 1'b1, 1'b0},
			'{1'b0, 9'h08E, 8'h09, 1'b1, 1'b0, 1'b0}, '{1'b1, 9'h08E, 8'h0D, 1'b1, 1'b0, 1'b0},
			'{1'b0, 9'h08E, 8'h18, 1'b0, 1'b0, 1'b0}, '{1'b1, 9'h08E, 8'h18, 1'b0, 1'b0, 1'b0}};
		cyc(16);
		reset_n = 1'b1;
		cyc(4);
		check({12'h000, shut, test_en, pd, oe_n}, 16'h0001);
		check(cvi | cvq, 16'h0000);
		foreach (rows[k]) begin
			pres = rows[k].pres;
			bal = rows[k].bal;
			cyc(8);
			frame(rows[k].rw, rows[k].addr, rows[k].d, 24, q);
			if (rows[k].rw) check({8'h00, q}, {8'h00, rows[k].d});
			check({15'h0000, pd}, {15'h0000, rows[k].pd});
		end
		check(cvi, 16'hC35A);
		check(cvq, 16'hA53C);
		check({14'h0000, test_en, shut}, 16'h0003);
		// A frame cut short after 20 bits must leave the constant alone.
		frame(1'b0, 9'h0F8, 8'h00, 20, q);
		check(cvi, 16'hC35A);
		// A second reset in mid-run returns everything that was programmed to its reset value.
		reset_n = 1'b0;
		cyc(4);
		reset_n = 1'b1;
		cyc(4);
		check(cvi | cvq, 16'h0000);
		check({13'h0000, shut, test_en, pd}, 16'h0000);
		frame(1'b1, 9'h0F7, 8'h00, 24, q);
		check({8'h00, q}, 16'h001C);
		end_sim;
	end
endmodule
